// ===== inc/demod_cfg_pkg.sv
package demod_cfg_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int         ADDR_W     = 5;
    localparam logic [4:0] A_RATE     = 5'h00;
    localparam logic [4:0] A_FREQ     = 5'h04;
    localparam logic [4:0] A_MODE     = 5'h08;
    localparam logic [4:0] A_SWC      = 5'h0C;
    localparam logic [4:0] A_SWW      = 5'h10;
    localparam logic [4:0] A_RQ       = 5'h14;
    localparam logic [4:0] A_CTRL     = 5'h18;
    localparam int         B_COMMIT   = 0;
    localparam int         B_CLR      = 1;

    // ------------------------------------------------------------
    // Ranges and reset values
    // ------------------------------------------------------------
    localparam logic [27:0] IF_MIN_HZ  = 28'h2FAF080;
    localparam logic [27:0] IF_MAX_HZ  = 28'hABA9500;
    localparam logic [27:0] IF_RST_HZ  = 28'h42C1D80;
    localparam logic [16:0] SWC_MAX    = 17'h088B8;
    localparam logic [16:0] SWC_MIN    = 17'h17748;
    localparam logic [16:0] SWW_MAX    = 17'h11170;
    localparam logic [16:0] SWW_RST    = 17'h0EA60;
    localparam logic [9:0]  RQ_MAX     = 10'h3E7;

    // Data rates in units of 100 bit/s
    localparam logic [17:0] R_64K      = 18'h00280;
    localparam logic [17:0] R_128K     = 18'h00500;
    localparam logic [17:0] R_256K     = 18'h00A00;
    localparam logic [17:0] R_512K     = 18'h01400;
    localparam logic [17:0] R_VAR_RST  = 18'h00180;
    localparam logic [17:0] R_BURST_LO = 18'h000C0;
    localparam logic [17:0] R_BURST_HI = 18'h00240;
    localparam logic [17:0] R_LOW_MAX  = 18'h01400;
    localparam logic [2:0]  PRESET_VAR = 3'h4;
    localparam logic [2:0]  PRESET_RST = 3'h0;

    localparam logic [3:0]  BER_NONE   = 4'h0;
    localparam logic [3:0]  BER_EXP_LO = 4'h3;
    localparam logic [3:0]  BER_EXP_HI = 4'h8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int REACQ_UNIT_S  = 1;
    localparam int CYC_PER_SEC   = 1_000_000_000 / CLK_PERIOD_NS * REACQ_UNIT_S;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CR_BPSK_12, CR_QPSK_12, CR_OQPSK_12, CR_QPSK_34, CR_OQPSK_34,
        CR_QPSK_78, CR_OQPSK_78, CR_8PSK_23, CR_BPSK_11, CR_QPSK_11,
        CR_OQPSK_11, CR_BPSK_2144, CR_BPSK_516, CR_8PSK_34
    } code_e;

    typedef enum logic [1:0] {RS_OFF, RS_ON, RS_CORR_OFF, RS_BAD} rs_e;

    typedef struct packed {
        logic [2:0]  preset;
        code_e       code;
        logic [17:0] rate;
        logic [27:0] freq;
        logic        descr;
        logic        diff;
        logic        rf;
        logic        ifl;
        logic [3:0]  ber;
        rs_e         rs;
        logic [16:0] swc;
        logic [16:0] sww;
        logic [9:0]  rq;
    } cfg_s;

    localparam cfg_s CFG_RST = '{PRESET_RST, CR_QPSK_12, R_VAR_RST, IF_RST_HZ,
                                 1'b1, 1'b1, 1'b0, 1'b0, BER_NONE, RS_OFF,
                                 17'h00000, SWW_RST, 10'h000};

endpackage

// ===== logic/demod_config_controller.sv
`timescale 1ns/10ps
module demod_config_controller #(
    parameter int CYC_PER_SEC = demod_cfg_pkg::CYC_PER_SEC,
    parameter int BER_REP_W   = 16
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire logic [4:0]            i_avs_address,
    input  wire logic                  i_avs_read,
    input  wire logic                  i_avs_write,
    input  wire logic [31:0]           i_avs_writedata,
    input  wire logic [3:0]            i_avs_byteenable,
    output logic      [31:0]           o_avs_readdata,
    output logic                       o_avs_waitrequest,
    input  wire logic                  i_burst_mode,
    input  wire logic                  i_low_var_rate,
    input  wire logic                  i_closed_network_overhead,
    input  wire logic                  i_seq_encoder,
    input  wire logic                  i_rs_ok,
    input  wire logic [27:0]           i_tx_freq,
    input  wire logic                  i_lock,
    input  wire logic [3:0]            i_ber_exp,
    input  wire logic [BER_REP_W-1:0]  i_inner_ber,
    input  wire logic [BER_REP_W-1:0]  i_outer_ber,
    output logic                       o_tx_off,
    output logic                       o_beep2,
    output logic                       o_rx_fault,
    output demod_cfg_pkg::code_e       o_code_rate,
    output logic      [17:0]           o_data_rate,
    output logic      [27:0]           o_tune_freq,
    output logic                       o_if_loop,
    output logic                       o_descr_en,
    output logic                       o_diffdec_en,
    output demod_cfg_pkg::rs_e         o_rs_mode,
    output logic      [BER_REP_W-1:0]  o_ber_report,
    output logic      [16:0]           o_sweep_center,
    output logic      [16:0]           o_sweep_width,
    output logic                       o_sweep_directed,
    output logic                       o_sweep_narrow
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (CYC_PER_SEC < 2 || BER_REP_W < 1) begin : g_bad
        $error("demod_config_controller: bad parameter");
    end

    localparam int SEC_W = $clog2(CYC_PER_SEC + 1);
    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(CYC_PER_SEC - 1);

    typedef enum logic {ACQ_NORMAL, ACQ_NARROW} acq_e;

    typedef struct packed {
        demod_cfg_pkg::cfg_s   stg;
        demod_cfg_pkg::cfg_s   act;
        demod_cfg_pkg::code_e  code;
        logic [17:0]           rate;
        logic [27:0]           tune;
        logic [31:0]           rdata;
        logic                  ack;
        logic                  tx_off;
        logic                  beep;
        logic                  fault;
        logic                  diff_o;
        logic                  lk1;
        logic                  lk2;
        logic                  lk3;
        logic                  rej_rate;
        logic                  rej_rs;
        logic                  rej_val;
        acq_e                  acq;
        logic [SEC_W-1:0]      sec;
        logic [9:0]            rq_left;
        logic [BER_REP_W-1:0]  ber;
    } st_s;

    localparam st_s ST_RST = '{demod_cfg_pkg::CFG_RST, demod_cfg_pkg::CFG_RST,
                               demod_cfg_pkg::CR_QPSK_12, demod_cfg_pkg::R_64K,
                               demod_cfg_pkg::IF_RST_HZ, 32'h00000000,
                               1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0,
                               1'b0, 1'b0, 1'b0, ACQ_NORMAL, '0, 10'h000, '0};

    st_s s;
    st_s n;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] pack(demod_cfg_pkg::cfg_s c, logic [4:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        case (a)
            demod_cfg_pkg::A_RATE: w = {6'h00, c.rate, c.code, 1'b0, c.preset};
            demod_cfg_pkg::A_FREQ: w = {4'h0, c.freq};
            demod_cfg_pkg::A_MODE: w = {22'h000000, c.rs, c.ber, c.ifl, c.rf,
                                        c.diff, c.descr};
            demod_cfg_pkg::A_SWC:  w = {{15{c.swc[16]}}, c.swc};
            demod_cfg_pkg::A_SWW:  w = {15'h0000, c.sww};
            demod_cfg_pkg::A_RQ:   w = {22'h000000, c.rq};
            default:               w = 32'h00000000;
        endcase
        return w;
    endfunction

    function automatic logic is34(demod_cfg_pkg::code_e c);
        return c == demod_cfg_pkg::CR_QPSK_34 || c == demod_cfg_pkg::CR_OQPSK_34
            || c == demod_cfg_pkg::CR_8PSK_34;
    endfunction

    function automatic logic burst_ok(demod_cfg_pkg::code_e c, logic [17:0] r);
        return c == demod_cfg_pkg::CR_QPSK_12
            && (r == demod_cfg_pkg::R_BURST_LO || r == demod_cfg_pkg::R_BURST_HI);
    endfunction

    function automatic logic [17:0] preset_rate(logic [2:0] p);
        case (p)
            3'h0:    return demod_cfg_pkg::R_64K;
            3'h1:    return demod_cfg_pkg::R_128K;
            3'h2:    return demod_cfg_pkg::R_256K;
            default: return demod_cfg_pkg::R_512K;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus decode and commit checks
    // ------------------------------------------------------------
    logic                  bus_go;
    logic                  commit;
    logic                  lock_fall;
    logic [31:0]           wr;
    demod_cfg_pkg::code_e  c_code;
    logic [17:0]           c_rate;
    logic                  c_ok;
    logic                  f_ok;
    logic                  b_ok;
    logic                  sw_ok;

    assign bus_go    = (i_avs_read | i_avs_write) & ~s.ack;
    assign commit    = i_avs_write & s.ack & (i_avs_address == demod_cfg_pkg::A_CTRL)
                     & i_avs_byteenable[0] & i_avs_writedata[demod_cfg_pkg::B_COMMIT];
    assign lock_fall = s.lk3 & ~s.lk2;

    always_comb begin
        n = s;
        wr = pack(s.stg, i_avs_address);
        for (int i = 0; i < 4; i++) begin
            wr[i*8 +: 8] = i_avs_byteenable[i] ? i_avs_writedata[i*8 +: 8] : wr[i*8 +: 8];
        end
        // Presets are fixed QPSK 1/2; only the variable slot is edited
        if (s.stg.preset < demod_cfg_pkg::PRESET_VAR) begin
            c_code = demod_cfg_pkg::CR_QPSK_12;
            c_rate = preset_rate(s.stg.preset);
        end else begin
            c_code = s.stg.code;
            c_rate = s.stg.rate;
        end
        c_ok = s.stg.preset <= demod_cfg_pkg::PRESET_VAR
            && s.stg.code <= demod_cfg_pkg::CR_8PSK_34
            && c_rate != 18'h00000
            && !(i_burst_mode && !burst_ok(c_code, c_rate))
            && !(is34(c_code) && i_closed_network_overhead
                 && i_seq_encoder)
            && !(i_low_var_rate && c_rate > demod_cfg_pkg::R_LOW_MAX);
        f_ok = s.stg.freq >= demod_cfg_pkg::IF_MIN_HZ
            && s.stg.freq <= demod_cfg_pkg::IF_MAX_HZ;
        b_ok = s.stg.ber == demod_cfg_pkg::BER_NONE
            || (s.stg.ber >= demod_cfg_pkg::BER_EXP_LO
                && s.stg.ber <= demod_cfg_pkg::BER_EXP_HI);
        sw_ok = $signed(s.stg.swc) >= $signed(demod_cfg_pkg::SWC_MIN)
             && $signed(s.stg.swc) <= $signed(demod_cfg_pkg::SWC_MAX)
             && s.stg.sww <= demod_cfg_pkg::SWW_MAX;

        n.tx_off = 1'b0;
        n.beep   = 1'b0;
        n.ack    = bus_go;
        n.lk1    = i_lock;
        n.lk2    = s.lk1;
        n.lk3    = s.lk2;

        // Reads show committed values so the current state is visible
        if (bus_go && i_avs_read) begin
            if (i_avs_address == demod_cfg_pkg::A_CTRL) begin
                n.rdata = {26'h0000000, s.rej_val, s.rej_rs, s.rej_rate, s.lk2,
                           s.acq == ACQ_NARROW, s.fault};
            end else begin
                n.rdata = pack(s.act, i_avs_address);
            end
        end

        // Writes land at the edge that sees waitrequest low; A_CTRL clears flags or commits, other addresses hit the staged copy only
        if (i_avs_write && s.ack) begin
            case (i_avs_address)
                demod_cfg_pkg::A_RATE: begin
                    n.stg.preset = wr[2:0];
                    n.stg.code   = demod_cfg_pkg::code_e'(wr[7:4]);
                    n.stg.rate   = wr[25:8];
                end
                demod_cfg_pkg::A_FREQ: n.stg.freq = wr[27:0];
                demod_cfg_pkg::A_MODE: begin
                    n.stg.descr = wr[0];
                    n.stg.diff  = wr[1];
                    n.stg.rf    = wr[2];
                    n.stg.ifl   = wr[3];
                    n.stg.ber   = wr[7:4];
                    n.stg.rs    = demod_cfg_pkg::rs_e'(wr[9:8]);
                end
                demod_cfg_pkg::A_SWC: n.stg.swc = wr[16:0];
                demod_cfg_pkg::A_SWW: n.stg.sww = wr[16:0];
                demod_cfg_pkg::A_RQ:  n.stg.rq  = wr[9:0];
                demod_cfg_pkg::A_CTRL: begin
                    if (i_avs_byteenable[0] && wr[demod_cfg_pkg::B_CLR]) begin
                        n.rej_rate = 1'b0;
                        n.rej_rs   = 1'b0;
                        n.rej_val  = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // --------------------------------------------------------
        // Commit: apply staged settings, later sets beat the clear
        // --------------------------------------------------------
        if (commit) begin
            if (c_ok) begin
                n.act.preset = s.stg.preset;
                n.act.code   = s.stg.code;
                n.act.rate   = s.stg.rate;
                n.code       = c_code;
                n.rate       = c_rate;
                n.tx_off     = c_code != s.code || c_rate != s.rate;
            end else begin
                n.rej_rate = 1'b1;
            end
            if (f_ok) begin
                n.act.freq = s.stg.freq;
            end
            if (b_ok) begin
                n.act.ber = s.stg.ber;
            end
            if (sw_ok && s.stg.rq <= demod_cfg_pkg::RQ_MAX) begin
                n.act.swc = s.stg.swc;
                n.act.sww = s.stg.sww;
                n.act.rq  = s.stg.rq;
            end
            if (!(f_ok && b_ok && sw_ok && s.stg.rq <= demod_cfg_pkg::RQ_MAX)
                || s.stg.rs == demod_cfg_pkg::RS_BAD) begin
                n.rej_val = 1'b1;
            end
            n.act.descr = s.stg.descr;
            n.act.diff  = s.stg.diff;
            // Newly enabled loopback wins; both new gives IF
            n.act.rf    = s.stg.rf & ~(s.stg.ifl & ~s.act.ifl);
            n.act.ifl   = s.stg.ifl & ~(s.stg.rf & s.act.ifl);
            if (s.stg.rs == demod_cfg_pkg::RS_ON && !i_rs_ok) begin
                n.beep   = 1'b1;
                n.rej_rs = 1'b1;
            end else if (s.stg.rs != demod_cfg_pkg::RS_BAD) begin
                n.act.rs = s.stg.rs;
            end
        end

        // --------------------------------------------------------
        // Reacquisition sweep timer
        // --------------------------------------------------------
        case (s.acq)
            ACQ_NORMAL: begin
                if (lock_fall && s.act.rq != 10'h000) begin
                    n.acq     = ACQ_NARROW;
                    n.sec     = '0;
                    n.rq_left = s.act.rq;
                end
            end
            ACQ_NARROW: begin
                if (s.lk2) begin
                    n.acq = ACQ_NORMAL;
                end else if (s.sec == SEC_LAST) begin
                    n.sec     = '0;
                    n.rq_left = s.rq_left - 10'h001;
                    if (s.rq_left == 10'h001) begin
                        n.acq = ACQ_NORMAL;
                    end
                end else begin
                    n.sec = s.sec + SEC_W'(1);
                end
            end
            default: n.acq = ACQ_NORMAL;
        endcase

        // Loopback tunes from TX; the stored frequency is left alone
        n.tune   = (s.act.rf | s.act.ifl) ? i_tx_freq : s.act.freq;
        n.diff_o = s.act.diff & ~i_burst_mode;
        n.fault  = s.act.ber != demod_cfg_pkg::BER_NONE
                   && i_ber_exp < s.act.ber;
        n.ber    = s.act.rs == demod_cfg_pkg::RS_ON ? i_outer_ber
                                                    : i_inner_ber;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_avs_waitrequest = bus_go;
    assign o_avs_readdata    = s.rdata;
    assign o_tx_off          = s.tx_off;
    assign o_beep2           = s.beep;
    assign o_rx_fault        = s.fault;
    assign o_code_rate       = s.code;
    assign o_data_rate       = s.rate;
    assign o_tune_freq       = s.tune;
    assign o_if_loop         = s.act.ifl;
    assign o_descr_en        = s.act.descr;
    assign o_diffdec_en      = s.diff_o;
    assign o_rs_mode         = s.act.rs;
    assign o_ber_report      = s.ber;
    assign o_sweep_center    = s.act.swc;
    assign o_sweep_width     = s.act.sww;
    // Full width means the ordinary acquisition sweep
    assign o_sweep_directed  = s.act.sww != demod_cfg_pkg::SWW_MAX;
    assign o_sweep_narrow    = s.acq == ACQ_NARROW;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_rs_refused;
        commit && s.stg.rs == demod_cfg_pkg::RS_ON && !i_rs_ok;
    endsequence
    sequence s_loss_no_timer;
        lock_fall && s.act.rq == 10'h000 && s.acq == ACQ_NORMAL;
    endsequence

    a_rate_tx_off: assert property (
        ($changed(s.rate) || $changed(s.code)) |-> o_tx_off)
        else $error("rate changed without tx off");
    a_burst_only: assert property (
        $past(i_burst_mode) && $changed(s.rate) |-> burst_ok(s.code, s.rate))
        else $error("illegal burst rate accepted");
    a_low_var_cap: assert property (
        $past(i_low_var_rate) && $changed(s.rate) |-> s.rate <= demod_cfg_pkg::R_LOW_MAX)
        else $error("low var rate above cap");
    a_no_three_q: assert property (
        $past(i_closed_network_overhead && i_seq_encoder) && $changed(s.code)
        |-> !is34(s.code))
        else $error("3/4 accepted with closed overhead");
    a_diff_burst: assert property (
        $past(i_burst_mode) |-> !o_diffdec_en)
        else $error("diff decoder on in burst");
    a_loop_excl: assert property (
        !(s.act.rf && s.act.ifl))
        else $error("both loopbacks on");
    a_loop_tune: assert property (
        s.act.rf |=> o_tune_freq == $past(i_tx_freq) && $stable(s.act.freq) || $past(commit))
        else $error("loopback tuning wrong");
    a_ber_fault: assert property (
        s.act.ber != 4'h0 && i_ber_exp < s.act.ber |=> o_rx_fault)
        else $error("fault missing");
    a_rs_beep: assert property (
        s_rs_refused |=> o_beep2 && o_rs_mode == $past(o_rs_mode))
        else $error("rs on not refused");
    a_reacq_zero: assert property (
        s_loss_no_timer |=> !o_sweep_narrow [*2])
        else $error("narrow sweep with zero timer");
    a_freq_range: assert property (
        s.act.freq >= demod_cfg_pkg::IF_MIN_HZ && s.act.freq <= demod_cfg_pkg::IF_MAX_HZ)
        else $error("frequency out of range");

endmodule

// ===== tb/demod_far_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Demodulator tuning hardware and modulator side
// ------------------------------------------------------------
module demod_far_model (
    input  wire logic        i_clk,
    input  wire logic        i_drop,
    input  wire logic [3:0]  i_ber,
    output logic      [27:0] o_tx_freq,
    output logic             o_lock,
    output logic      [3:0]  o_ber_exp,
    output logic      [15:0] o_inner_ber,
    output logic      [15:0] o_outer_ber
);
    // Distinct values so a wrong selection shows
    assign o_tx_freq   = 28'h5F5E100;
    assign o_inner_ber = 16'h1234;
    assign o_outer_ber = 16'hABCD;
    always_ff @(posedge i_clk) begin
        o_lock    <= ~i_drop;
        o_ber_exp <= i_ber;
    end
endmodule

// ===== tb/demod_config_controller_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module demod_config_controller_tb;
    logic i_clk = 0, i_srst = 1, i_avs_read = 0, i_avs_write = 0, drop = 0;
    logic i_burst_mode = 0, i_low_var_rate = 0, i_closed_network_overhead = 0;
    logic i_seq_encoder = 0, i_rs_ok = 0, o_avs_waitrequest, o_tx_off, o_beep2, o_rx_fault;
    logic o_if_loop, o_descr_en, o_diffdec_en, o_sweep_directed, o_sweep_narrow;
    logic [4:0] i_avs_address = '0;
    logic [31:0] i_avs_writedata = '0, o_avs_readdata, q;
    logic [3:0] i_avs_byteenable = 4'hF, ber = 4'hF, i_ber_exp;
    logic [27:0] i_tx_freq, o_tune_freq, f;
    logic i_lock;
    logic [15:0] i_inner_ber, i_outer_ber, o_ber_report;
    logic [17:0] o_data_rate;
    logic [16:0] o_sweep_center, o_sweep_width;
    demod_cfg_pkg::code_e o_code_rate;
    demod_cfg_pkg::rs_e o_rs_mode;
    int mismatches = 0, tests_run = 0, n_off = 0, n_beep = 0, cyc = 0, n;
    always #2 i_clk = ~i_clk;
    demod_config_controller #(.CYC_PER_SEC(10)) demod_config_controller_i (
        .i_clk(i_clk), .i_srst(i_srst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_burst_mode(i_burst_mode),
        .i_low_var_rate(i_low_var_rate),
        .i_closed_network_overhead(i_closed_network_overhead), .i_seq_encoder(i_seq_encoder),
        .i_rs_ok(i_rs_ok), .i_tx_freq(i_tx_freq), .i_lock(i_lock), .i_ber_exp(i_ber_exp),
        .i_inner_ber(i_inner_ber), .i_outer_ber(i_outer_ber), .o_tx_off(o_tx_off),
        .o_beep2(o_beep2), .o_rx_fault(o_rx_fault), .o_code_rate(o_code_rate),
        .o_data_rate(o_data_rate), .o_tune_freq(o_tune_freq), .o_if_loop(o_if_loop),
        .o_descr_en(o_descr_en), .o_diffdec_en(o_diffdec_en), .o_rs_mode(o_rs_mode),
        .o_ber_report(o_ber_report), .o_sweep_center(o_sweep_center),
        .o_sweep_width(o_sweep_width), .o_sweep_directed(o_sweep_directed),
        .o_sweep_narrow(o_sweep_narrow));
    demod_far_model demod_far_model_i (.i_clk(i_clk), .i_drop(drop), .i_ber(ber),
        .o_tx_freq(i_tx_freq), .o_lock(i_lock), .o_ber_exp(i_ber_exp),
        .o_inner_ber(i_inner_ber), .o_outer_ber(i_outer_ber));
    // ------------------------------------------------------------
    // Pulse counters and hang guard
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        n_off += (o_tx_off === 1'b1);
        n_beep += (o_beep2 === 1'b1);
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic fault_exp(input logic [3:0] thr, input logic [3:0] meas);
        return thr != 4'h0 && meas < thr;
    endfunction
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input int w, input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w != 0;
        i_avs_read <= w == 0;
        @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_clk);
        q = o_avs_readdata;
        i_avs_write <= 0;
        i_avs_read <= 0;
    endtask
    task automatic cmt();
        bus(1, demod_cfg_pkg::A_CTRL, 32'h1);
        repeat (4) @(posedge i_clk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h97E0));
        repeat (5) @(posedge i_clk);
        i_srst <= 0;
        @(posedge i_clk);
        `CHK(o_tune_freq, demod_cfg_pkg::IF_RST_HZ)
        bus(0, demod_cfg_pkg::A_MODE, 0);
        `CHK(q, 32'h3)
        $display("reset test done");
        f = demod_cfg_pkg::IF_MIN_HZ + 28'($urandom % 130000001);
        bus(1, demod_cfg_pkg::A_FREQ, 32'(f));
        repeat (4) @(posedge i_clk);
        `CHK(o_tune_freq, demod_cfg_pkg::IF_RST_HZ)
        cmt();
        `CHK(o_tune_freq, f)
        bus(1, demod_cfg_pkg::A_FREQ, 32'(demod_cfg_pkg::IF_MAX_HZ) + 1);
        cmt();
        `CHK(o_tune_freq, f)
        $display("frequency test done");
        bus(1, demod_cfg_pkg::A_MODE, 32'h7);
        cmt();
        `CHK(o_tune_freq, i_tx_freq)
        bus(1, demod_cfg_pkg::A_MODE, 32'hF);
        cmt();
        `CHK(o_if_loop, 1'b1)
        bus(0, demod_cfg_pkg::A_MODE, 0);
        `CHK(q[3:2], 2'b10)
        bus(1, demod_cfg_pkg::A_MODE, 32'h2);
        cmt();
        `CHK(o_tune_freq, f)
        `CHK(o_if_loop, 1'b0)
        `CHK(o_descr_en, 1'b0)
        $display("loopback test done");
        n = n_off;
        bus(1, demod_cfg_pkg::A_RATE, 32'h11);
        cmt();
        `CHK(o_data_rate, demod_cfg_pkg::R_128K)
        `CHK(o_code_rate, demod_cfg_pkg::CR_QPSK_12)
        `CHK(n_off, n + 1)
        i_closed_network_overhead <= 1;
        i_seq_encoder <= 1;
        bus(1, demod_cfg_pkg::A_RATE, 32'({demod_cfg_pkg::R_64K, 8'h34}));
        cmt();
        `CHK(o_data_rate, demod_cfg_pkg::R_128K)
        bus(0, demod_cfg_pkg::A_CTRL, 0);
        `CHK(q[3], 1'b1)
        $display("rate test done");
        bus(1, demod_cfg_pkg::A_MODE, 32'h53);
        ber <= 4'h4;
        cmt();
        `CHK(o_rx_fault, fault_exp(4'h5, 4'h4))
        `CHK(o_descr_en, 1'b1)
        ber <= 4'h6;
        repeat (4) @(posedge i_clk);
        `CHK(o_rx_fault, fault_exp(4'h5, 4'h6))
        n = n_beep;
        bus(1, demod_cfg_pkg::A_MODE, 32'h103);
        cmt();
        `CHK(n_beep, n + 1)
        `CHK(o_rs_mode, demod_cfg_pkg::RS_OFF)
        i_rs_ok <= 1;
        cmt();
        `CHK(o_rs_mode, demod_cfg_pkg::RS_ON)
        `CHK(o_ber_report, i_outer_ber)
        i_burst_mode <= 1;
        repeat (4) @(posedge i_clk);
        `CHK(o_diffdec_en, 1'b0)
        $display("mode test done");
        bus(1, demod_cfg_pkg::A_RATE, 32'({demod_cfg_pkg::R_64K, 8'h14}));
        cmt();
        `CHK(o_data_rate, demod_cfg_pkg::R_128K)
        bus(1, demod_cfg_pkg::A_RATE, 32'({demod_cfg_pkg::R_BURST_LO, 8'h14}));
        cmt();
        `CHK(o_data_rate, demod_cfg_pkg::R_BURST_LO)
        i_burst_mode <= 0;
        i_low_var_rate <= 1;
        bus(1, demod_cfg_pkg::A_RATE, 32'({demod_cfg_pkg::R_LOW_MAX + 18'h1, 8'h14}));
        cmt();
        `CHK(o_data_rate, demod_cfg_pkg::R_BURST_LO)
        bus(1, demod_cfg_pkg::A_RATE, 32'({demod_cfg_pkg::R_LOW_MAX, 8'h14}));
        cmt();
        `CHK(o_data_rate, demod_cfg_pkg::R_LOW_MAX)
        $display("burst and low rate test done");
        bus(1, demod_cfg_pkg::A_SWW, 32'(demod_cfg_pkg::SWW_MAX));
        // Lane 0 only: upper lanes must keep the staged bits
        i_avs_byteenable <= 4'h1;
        bus(1, demod_cfg_pkg::A_RQ, 32'hFFFFFF02);
        i_avs_byteenable <= 4'hF;
        cmt();
        `CHK(o_sweep_directed, 1'b0)
        `CHK(o_sweep_width, demod_cfg_pkg::SWW_MAX)
        drop <= 1;
        repeat (8) @(posedge i_clk);
        `CHK(o_sweep_narrow, 1'b1)
        repeat (30) @(posedge i_clk);
        `CHK(o_sweep_narrow, 1'b0)
        drop <= 0;
        bus(1, demod_cfg_pkg::A_RQ, 0);
        cmt();
        drop <= 1;
        repeat (8) @(posedge i_clk);
        `CHK(o_sweep_narrow, 1'b0)
        bus(1, demod_cfg_pkg::A_SWC, 32'(demod_cfg_pkg::SWC_MIN));
        cmt();
        `CHK(o_sweep_center, demod_cfg_pkg::SWC_MIN)
        bus(1, demod_cfg_pkg::A_SWC, 32'(demod_cfg_pkg::SWC_MAX) + 1);
        cmt();
        `CHK(o_sweep_center, demod_cfg_pkg::SWC_MIN)
        $display("sweep test done");
        conclude();
    end
endmodule
